// file: dv/legacy_display_io_router_test.sv
// Self-checking bench for the legacy display I/O router.
`timescale 1ns/1ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin n_fail++; \
   $display("[ERR] %0t got %h exp %h", $time, (g), (e)); end end
module legacy_display_io_router_test;
   import ldr_pkg::*;
   // -------------------------------------------------------------------
   // Signals
   // -------------------------------------------------------------------
   logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
   logic [7:0]  awaddr, araddr;
   logic [31:0] wdata, rdata, req_addr, rnd;
   logic [3:0]  wstrb, req_be, route_target;
   logic [1:0]  bresp, rresp;
   logic        awready, wready, bvalid, arready, rvalid, req_valid, req_is_io;
   logic [2:0]  ge, isa, sg_count;
   logic        route_valid, route_display, route_mono, ack, mdp, sg_seen;
   logic [33:0] axq[$];
   logic [5:0]  rq[$];
   logic [7:0]  sq[$];
   logic [7:0]  gcnt;
   logic [3:0]  cfg_exp;
   int          n_fail, samples_checked;

   legacy_display_io_router #(.N_SEC(3)) dut (
      .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .req_valid(req_valid), .req_is_io(req_is_io), .req_addr(req_addr), .req_be(req_be),
      .graphics_route_enable(ge), .isa_enable(isa),
      .io_window_base({16'h0380, 16'h0300, 16'h0000}),
      .io_window_limit({16'h03FF, 16'h03FF, 16'h00FF}),
      .stop_grant_seen(sg_seen), .route_valid(route_valid), .route_target(route_target),
      .route_display(route_display), .route_mono(route_mono), .stop_grant_ack(ack),
      .stop_grant_count(sg_count), .mono_display_present(mdp));
   stop_grant_source src (.aclk(aclk), .stop_grant_seen(sg_seen));

   // -------------------------------------------------------------------
   // Clock, verdict and watchdog
   // -------------------------------------------------------------------
   initial begin
      aclk = 1'b0;
      forever #2.5 aclk = ~aclk;
   end
   task automatic give_verdict;
      if (n_fail == 0 && samples_checked > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   // About 250 cycles are expected; ten thousand leaves ample slack.
   initial begin
      #50000;
      n_fail++;
      give_verdict;
   end

   // -------------------------------------------------------------------
   // Drivers
   // -------------------------------------------------------------------
   // Live config outputs packed in the same order as the write notes.
   function automatic logic [3:0] stop_grant_cfg();
      return {sg_count, mdp};
   endfunction
   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction
   // Both halves offered together; each drops on its own handshake edge.
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] resp);
      @(posedge aclk);
      awaddr <= a; wdata <= d; wstrb <= 4'h3; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
      // Config fields expected once the response arrives; a refused write leaves them alone.
      if (resp == RESP_OKAY) cfg_exp = {d[SGC_MSB:SGC_LSB], d[MDP_BIT]};
      axq.push_back({28'h000_0000, cfg_exp, resp});
      do begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
      end while (!bvalid);
      bready <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] resp);
      @(posedge aclk);
      araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
      axq.push_back({d, resp});
      do begin
         @(posedge aclk);
         if (arvalid && arready) arvalid <= 1'b0;
      end while (!rvalid);
      rready <= 1'b0;
   endtask
   // Leaves req_valid high so that successive calls give back-to-back requests.
   task automatic route(input logic io, input logic [31:0] a, input logic [3:0] be,
                        input logic [3:0] t, input logic d, input logic m);
      @(posedge aclk);
      req_valid <= 1'b1; req_is_io <= io; req_addr <= a; req_be <= be;
      rq.push_back({t, d, m});
   endtask
   task automatic cfg(input logic [2:0] g, input logic [2:0] i);
      @(posedge aclk);
      req_valid <= 1'b0; ge <= g; isa <= i;
   endtask

   // -------------------------------------------------------------------
   // Output watcher: pops the oldest note whenever a result shows up
   // -------------------------------------------------------------------
   always @(posedge aclk) begin
      if (bvalid && bready) `CHK({28'h000_0000, stop_grant_cfg(), bresp}, axq.pop_front())
      if (rvalid && rready) `CHK({rdata, rresp}, axq.pop_front())
      if (route_valid) `CHK({route_target, route_display, route_mono}, rq.pop_front())
      if (ack) begin
         `CHK(gcnt, sq.pop_front())
         gcnt <= {7'h00, sg_seen};
      end else begin
         gcnt <= gcnt + {7'h00, sg_seen};
      end
   end

   // -------------------------------------------------------------------
   // Main sequence
   // -------------------------------------------------------------------
   initial begin
      {awvalid, wvalid, bready, arvalid, rready, req_valid, req_is_io} = '0;
      {awaddr, araddr, wdata, wstrb, req_addr, req_be, ge} = '0;
      isa = 3'h4; gcnt = 8'h00; n_fail = 0; samples_checked = 0; rnd = 32'h0000_29cc;
      cfg_exp = 4'h0;
      aresetn = 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      rd(CFG_OFFSET, {16'h0000, CFG_RESET}, RESP_OKAY);
      rd(8'h60, 32'h0000_0000, RESP_SLVERR);
      wr(8'h60, 32'hFFFF_FFFF, RESP_SLVERR);
      wr(STATUS_OFFSET, 32'h0000_0007, RESP_SLVERR);
      rd(CFG_OFFSET, {16'h0000, CFG_RESET}, RESP_OKAY);
      // Every count value, grants alternately back to back and spaced.
      for (int c = 0; c < 8; c++) begin
         wr(CFG_OFFSET, {16'h0000, c[2:0], 13'h0000}, RESP_OKAY);
         rd(CFG_OFFSET, {16'h0000, c[2:0], 13'h0000}, RESP_OKAY);
         sq.push_back(8'(c + 1));
         src.burst(c + 1, (c % 2) * 2);
         repeat (4) @(posedge aclk);
      end
      rd(STATUS_OFFSET, 32'h0000_0000, RESP_OKAY);
      // No graphics link enabled: everything lands on the primary link.
      route(1'b1, 32'h0000_03BC, 4'h1, 4'h1, 1'b1, 1'b0);
      route(1'b1, 32'h0000_03B4, 4'h1, 4'h1, 1'b1, 1'b1);
      route(1'b0, 32'h000A_0000, 4'h1, 4'h1, 1'b1, 1'b0);
      cfg(3'h2, 3'h4);
      route(1'b1, 32'h0000_03C0, 4'h1, 4'h4, 1'b1, 1'b0);
      route(1'b0, 32'h000B_7FFF, 4'h8, 4'h1, 1'b1, 1'b1);
      route(1'b0, 32'h000B_8000, 4'h1, 4'h4, 1'b1, 1'b0);
      route(1'b1, 32'h0000_FFB4, 4'h1, 4'h1, 1'b1, 1'b1);
      route(1'b1, 32'h0000_03B8, 4'h9, 4'h1, 1'b1, 1'b1);
      route(1'b1, 32'h0000_03BC, 4'h2, 4'h4, 1'b1, 1'b0);
      cfg(3'h4, 3'h6);
      route(1'b1, 32'h0000_03BC, 4'h4, 4'h1, 1'b1, 1'b0);
      cfg(3'h2, 3'h4);
      wr(CFG_OFFSET, 32'h0000_E020, RESP_OKAY);
      rd(CFG_OFFSET, 32'h0000_E020, RESP_OKAY);
      route(1'b1, 32'h0000_03B4, 4'h1, 4'h4, 1'b1, 1'b1);
      route(1'b0, 32'h000B_0000, 4'h1, 4'h4, 1'b1, 1'b1);
      // Random memory far above the display ranges stays on the primary link.
      for (int i = 0; i < 8; i++) begin
         rnd = lfsr(rnd);
         route(1'b0, {4'h1, rnd[27:0]}, rnd[3:0], 4'h1, 1'b0, 1'b0);
      end
      cfg(3'h2, 3'h4);
      repeat (4) @(posedge aclk);
      `CHK(axq.size() + rq.size() + sq.size(), 0)
      give_verdict;
   end
endmodule

// file: dv/stop_grant_source.sv
// Processor-bus side model that emits stop-grant transaction pulses.
`timescale 1ns/1ps
module stop_grant_source (
   input  wire logic aclk,
   output logic      stop_grant_seen
);
   initial stop_grant_seen = 1'b0;

   // -------------------------------------------------------------------
   // Grant bursts
   // -------------------------------------------------------------------
   // Emits n one-cycle grants, gap idle cycles apart; gap 0 makes them back to back.
   // With a nonzero gap the line drops between grants, so a stuck counter input cannot hide a miscount.
   task automatic burst(input int n, input int gap);
      for (int i = 0; i < n; i++) begin
         @(posedge aclk);
         stop_grant_seen <= 1'b1;
         for (int j = 0; j < gap; j++) begin
            @(posedge aclk);
            stop_grant_seen <= 1'b0;
         end
      end
      @(posedge aclk);
      stop_grant_seen <= 1'b0;
   endtask
endmodule

// file: verilog/ldr_pkg.sv
// Constants shared by the legacy display I/O router.
package ldr_pkg;
   // -------------------------------------------------------------------
   // Register map
   // -------------------------------------------------------------------
   localparam int          ADDR_W        = 8;
   localparam logic [7:0]  CFG_OFFSET    = 8'h50;
   localparam logic [7:0]  STATUS_OFFSET = 8'h54;
   localparam logic [15:0] CFG_RESET     = 16'h0000;
   localparam int          SGC_LSB       = 13;
   localparam int          SGC_MSB       = 15;
   localparam int          MDP_BIT       = 5;
   localparam logic [1:0]  RESP_OKAY     = 2'h0;
   localparam logic [1:0]  RESP_SLVERR   = 2'h2;

   // -------------------------------------------------------------------
   // Legacy display address ranges
   // -------------------------------------------------------------------
   localparam logic [31:0] MONO_MEM_LO   = 32'h000B_0000;
   localparam logic [31:0] MONO_MEM_HI   = 32'h000B_7FFF;
   localparam logic [31:0] COLOUR_MEM_LO = 32'h000A_0000;
   localparam logic [31:0] COLOUR_MEM_HI = 32'h000B_FFFF;
   localparam logic [9:0]  PRN_IO_LO     = 10'h3BC;
   localparam logic [9:0]  PRN_IO_HI     = 10'h3BF;
   localparam logic [9:0]  MONO_IO_A     = 10'h3B4;
   localparam logic [9:0]  MONO_IO_B     = 10'h3B5;
   localparam logic [9:0]  MONO_IO_C     = 10'h3B8;
   localparam logic [9:0]  MONO_IO_D     = 10'h3B9;
   localparam logic [9:0]  MONO_IO_E     = 10'h3BA;
   localparam logic [9:0]  MONO_IO_F     = 10'h3BF;
   localparam logic [9:0]  COLOUR_IO_LO  = 10'h3C0;
   localparam logic [9:0]  COLOUR_IO_HI  = 10'h3DF;
   localparam logic [9:0]  COLOUR_B_LO   = 10'h3B0;
   localparam logic [9:0]  COLOUR_B_HI   = 10'h3BB;
endpackage

// file: verilog/legacy_display_io_router.sv
// Legacy display I/O router with stop-grant counter and AXI4-Lite config.
// Behaviour
// - Acknowledge after stop_grant_count plus one grants.
// - Stop-grant count stays writable at all times.
// - No graphics enable: printer range to primary.
// - Printer range to secondary only inside window.
// - Memory B0000-B7FFF counts as monochrome.
// - Mono I/O decode ignores address bits 15:10.
// - Any touched mono location makes mono reference.
// - No graphics, no mono: all to primary.
`timescale 1ns/1ps
module legacy_display_io_router #(
   parameter int N_SEC = 3
) (
   input  wire logic                             aclk,
   input  wire logic                             aresetn,
   input  wire logic [ldr_pkg::ADDR_W-1:0]       s_axi_awaddr,
   input  wire logic                             s_axi_awvalid,
   output logic                                  s_axi_awready,
   input  wire logic [31:0]                      s_axi_wdata,
   input  wire logic [3:0]                       s_axi_wstrb,
   input  wire logic                             s_axi_wvalid,
   output logic                                  s_axi_wready,
   output logic [1:0]                            s_axi_bresp,
   output logic                                  s_axi_bvalid,
   input  wire logic                             s_axi_bready,
   input  wire logic [ldr_pkg::ADDR_W-1:0]       s_axi_araddr,
   input  wire logic                             s_axi_arvalid,
   output logic                                  s_axi_arready,
   output logic [31:0]                           s_axi_rdata,
   output logic [1:0]                            s_axi_rresp,
   output logic                                  s_axi_rvalid,
   input  wire logic                             s_axi_rready,
   input  wire logic                             req_valid,
   input  wire logic                             req_is_io,
   input  wire logic [31:0]                      req_addr,
   input  wire logic [3:0]                       req_be,
   input  wire logic [N_SEC-1:0]                 graphics_route_enable,
   input  wire logic [N_SEC-1:0]                 isa_enable,
   input  wire logic [N_SEC*16-1:0]              io_window_base,
   input  wire logic [N_SEC*16-1:0]              io_window_limit,
   input  wire logic                             stop_grant_seen,
   output logic                                  route_valid,
   output logic [N_SEC:0]                        route_target,
   output logic                                  route_display,
   output logic                                  route_mono,
   output logic                                  stop_grant_ack,
   output logic [2:0]                            stop_grant_count,
   output logic                                  mono_display_present
);
   import ldr_pkg::*;

   localparam logic [N_SEC:0] PRIMARY = {{N_SEC{1'b0}}, 1'b1};

   // -------------------------------------------------------------------
   // Decode helpers
   // -------------------------------------------------------------------

   // Monochrome I/O location match on the low ten address bits only.
   function automatic logic mono_io(input logic [9:0] a);
      mono_io = (a == MONO_IO_A) || (a == MONO_IO_B) || (a == MONO_IO_C) ||
                (a == MONO_IO_D) || (a == MONO_IO_E) || (a == MONO_IO_F);
   endfunction

   // Lowest set bit as a one-hot vector; fixes the choice when several links qualify.
   function automatic logic [N_SEC-1:0] lowest_one(input logic [N_SEC-1:0] v);
      lowest_one = v & (~v + {{(N_SEC-1){1'b0}}, 1'b1});
   endfunction

   // -------------------------------------------------------------------
   // Address classification
   // -------------------------------------------------------------------
   logic [3:0]       mono_lane;
   logic [3:0]       colour_lane;
   logic [3:0]       prn_lane;
   logic [N_SEC-1:0] win_ok;
   logic             mono_hit;
   logic             colour_hit;
   logic             prn_hit;
   logic             any_vga;
   logic [N_SEC-1:0] vga_oh;
   logic [N_SEC-1:0] prn_oh;

   // Every enabled byte lane is decoded so a wide access that merely
   // overlaps a legacy location is still caught.
   genvar g;
   generate
      for (g = 0; g < 4; g++) begin : g_lane
         logic [9:0] la;
         assign la             = {req_addr[9:2], 2'(g)};
         assign mono_lane[g]   = req_be[g] && mono_io(la);
         assign colour_lane[g] = req_be[g] &&
                                 (((la >= COLOUR_IO_LO) && (la <= COLOUR_IO_HI)) ||
                                  ((la >= COLOUR_B_LO) && (la <= COLOUR_B_HI)));
         assign prn_lane[g]    = req_be[g] && (la >= PRN_IO_LO) && (la <= PRN_IO_HI);
      end
      for (g = 0; g < N_SEC; g++) begin : g_win
         assign win_ok[g] = (req_addr[15:0] >= io_window_base[g*16 +: 16]) &&
                            (req_addr[15:0] <= io_window_limit[g*16 +: 16]);
      end
   endgenerate

   // Memory matches use the full address; I/O matches use the lanes.
   assign mono_hit   = req_is_io ? (|mono_lane) :
                       ((req_addr >= MONO_MEM_LO) && (req_addr <= MONO_MEM_HI));
   assign colour_hit = req_is_io ? (|colour_lane) :
                       ((req_addr >= COLOUR_MEM_LO) && (req_addr <= COLOUR_MEM_HI));
   assign prn_hit    = req_is_io && (|prn_lane);
   assign any_vga    = |graphics_route_enable;
   assign vga_oh     = lowest_one(graphics_route_enable);
   assign prn_oh     = lowest_one(win_ok & ~isa_enable);

   // -------------------------------------------------------------------
   // Routing decision
   // -------------------------------------------------------------------
   logic [N_SEC:0] tgt_d;
   logic           disp_d;
   logic           mono_d;

   // Mono wins over the printer range because 3BFh sits in both sets.
   always_comb begin
      tgt_d  = PRIMARY;
      disp_d = 1'b0;
      mono_d = 1'b0;
      if (mono_hit) begin
         disp_d = 1'b1;
         mono_d = 1'b1;
         if (any_vga && mono_display_present) begin
            tgt_d = {vga_oh, 1'b0};
         end
      end else if (colour_hit) begin
         disp_d = 1'b1;
         if (any_vga) begin
            tgt_d = {vga_oh, 1'b0};
         end
      end else if (prn_hit) begin
         disp_d = 1'b1;
         if (any_vga && (|prn_oh)) begin
            tgt_d = {prn_oh, 1'b0};
         end
      end
   end

   // One cycle of latency keeps the route outputs glitch free.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         route_valid   <= 1'b0;
         route_target  <= PRIMARY;
         route_display <= 1'b0;
         route_mono    <= 1'b0;
      end else begin
         route_valid <= req_valid;
         if (req_valid) begin
            route_target  <= tgt_d;
            route_display <= disp_d;
            route_mono    <= mono_d;
         end
      end
   end

   // -------------------------------------------------------------------
   // Stop-grant counter
   // -------------------------------------------------------------------
   logic [2:0] sg_cnt_q;

   // The >= compare recovers if software shrinks the count mid-sequence.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sg_cnt_q       <= 3'h0;
         stop_grant_ack <= 1'b0;
      end else begin
         stop_grant_ack <= 1'b0;
         if (stop_grant_seen) begin
            if (sg_cnt_q >= stop_grant_count) begin
               sg_cnt_q       <= 3'h0;
               stop_grant_ack <= 1'b1;
            end else begin
               sg_cnt_q <= sg_cnt_q + 3'h1;
            end
         end
      end
   end

   // -------------------------------------------------------------------
   // AXI4-Lite slave
   // -------------------------------------------------------------------
   logic [ADDR_W-1:0] aw_q;
   logic              aw_have_q;
   logic [31:0]       wd_q;
   logic [3:0]        ws_q;
   logic              w_have_q;
   logic              wr_fire;

   assign s_axi_awready = !aw_have_q && !s_axi_bvalid;
   assign s_axi_wready  = !w_have_q && !s_axi_bvalid;
   assign s_axi_arready = !s_axi_rvalid;
   assign wr_fire       = aw_have_q && w_have_q && !s_axi_bvalid;

   // Address and data are parked separately so either may come first.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_q         <= '0;
         aw_have_q    <= 1'b0;
         wd_q         <= 32'h0000_0000;
         ws_q         <= 4'h0;
         w_have_q     <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_q      <= s_axi_awaddr;
            aw_have_q <= 1'b1;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wd_q     <= s_axi_wdata;
            ws_q     <= s_axi_wstrb;
            w_have_q <= 1'b1;
         end
         if (wr_fire) begin
            aw_have_q    <= 1'b0;
            w_have_q     <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (aw_q == CFG_OFFSET) ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // Configuration fields; never locked, each write lands in the fields whose byte strobe is set.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         stop_grant_count     <= CFG_RESET[SGC_MSB:SGC_LSB];
         mono_display_present <= CFG_RESET[MDP_BIT];
      end else if (wr_fire && (aw_q == CFG_OFFSET)) begin
         if (ws_q[1]) begin
            stop_grant_count <= wd_q[SGC_MSB:SGC_LSB];
         end
         if (ws_q[0]) begin
            mono_display_present <= wd_q[MDP_BIT];
         end
      end
   end

   // Read path; status word exposes the live stop-grant progress.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp  <= RESP_OKAY;
         s_axi_rdata  <= 32'h0000_0000;
         if (s_axi_araddr == CFG_OFFSET) begin
            s_axi_rdata[SGC_MSB:SGC_LSB] <= stop_grant_count;
            s_axi_rdata[MDP_BIT]         <= mono_display_present;
         end else if (s_axi_araddr == STATUS_OFFSET) begin
            s_axi_rdata[2:0] <= sg_cnt_q;
         end else begin
            s_axi_rresp <= RESP_SLVERR;
         end
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // -------------------------------------------------------------------
   // Checks
   // -------------------------------------------------------------------
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   // Independent tally of grants since the last acknowledge.
   logic [3:0] seen_tally_q;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         seen_tally_q <= 4'h0;
      end else if (stop_grant_ack) begin
         seen_tally_q <= stop_grant_seen ? 4'h1 : 4'h0;
      end else if (stop_grant_seen) begin
         seen_tally_q <= seen_tally_q + 4'h1;
      end
   end

   sequence s_cfg_write;
      wr_fire && (aw_q == CFG_OFFSET) && ws_q[1];
   endsequence

   sequence s_io_req;
      req_valid && req_is_io;
   endsequence

   chk_sg_ack_count: assert property (
      stop_grant_ack && $stable(stop_grant_count) |->
         seen_tally_q == ({1'b0, stop_grant_count} + 4'h1))
      else $error("stop-grant acknowledge after wrong number of grants");

   chk_cfg_always_rw: assert property (
      s_cfg_write |=> stop_grant_count == $past(wd_q[SGC_MSB:SGC_LSB]))
      else $error("stop-grant count write did not take effect");

   chk_printer_primary: assert property (
      s_io_req ##0 (prn_hit && !mono_hit && !any_vga) |=> route_target == PRIMARY)
      else $error("printer range not sent to primary link");

   chk_printer_window: assert property (
      s_io_req ##0 (prn_hit && !mono_hit && any_vga) |=>
         route_target == ($past(|prn_oh) ? {$past(prn_oh), 1'b0} : PRIMARY))
      else $error("printer range routed outside its window rule");

   chk_mono_memory: assert property (
      req_valid && !req_is_io && (req_addr >= MONO_MEM_LO) &&
         (req_addr <= MONO_MEM_HI) |=> route_mono && route_display)
      else $error("monochrome memory not flagged");

   chk_mono_alias: assert property (
      s_io_req ##0 (req_be[0] && (req_addr[9:0] == MONO_IO_A)) |=> route_mono && route_display)
      else $error("aliased monochrome location missed");
   chk_mono_wide_ref: assert property (
      s_io_req ##0 ((|mono_lane) && (|(req_be & ~mono_lane))) |=> route_mono)
      else $error("wide reference touching mono not flagged");
   chk_no_vga_primary: assert property (
      req_valid && disp_d && !any_vga && !mono_display_present |=>
         route_target == PRIMARY)
      else $error("display reference left primary link");
   chk_colour_vga: assert property (
      req_valid && colour_hit && !mono_hit && any_vga |=>
         route_target == {$past(vga_oh), 1'b0})
      else $error("colour reference not on graphics link");
   chk_mono_follows: assert property (
      req_valid && mono_hit && any_vga |=>
         route_target == ($past(mono_display_present) ? {$past(vga_oh), 1'b0} : PRIMARY))
      else $error("monochrome reference on wrong link");
endmodule
